// ===== pkg/msp_defines.vh
`ifndef MSP_DEFINES_VH
`define MSP_DEFINES_VH

// Command byte layout
`define MSP_CMD_WRITE_BIT 7
`define MSP_ADDR_W 5
`define MSP_CMD_BITS 6'h08

// Shift path sizing
`define MSP_SHIFT_W 40
`define MSP_CNT_W 6
`define MSP_BYTE_W 8
`define MSP_SEL_W 3
`define MSP_CHK_W 6

// Write FIFO word: {addr, byte select, last flag, data}
`define MSP_WQ_W 17
`define MSP_WQ_DEPTH 8

// Register addresses and default width in bits
`define MSP_ADDR_WAVE 5'h01
`define MSP_ADDR_ENERGY 5'h02
`define MSP_ADDR_RENERGY 5'h03
`define MSP_ADDR_STAT 5'h04
`define MSP_ADDR_RSTAT 5'h05
`define MSP_ADDR_MODEREG 5'h06
`define MSP_ADDR_DIVDEN 5'h07
`define MSP_ADDR_OFS1 5'h08
`define MSP_ADDR_OFS2 5'h09
`define MSP_ADDR_PGA 5'h0A
`define MSP_ADDR_PWRGAIN 5'h0B
`define MSP_ADDR_PHASE 5'h0C
`define MSP_ADDR_PWROFS 5'h0D
`define MSP_ADDR_ZXTO 5'h0E
`define MSP_ADDR_SAGN 5'h0F
`define MSP_ADDR_IRQMASK 5'h10
`define MSP_ADDR_CHECKSUM 5'h1E
`define MSP_BITS_DEFAULT 6'h08

// Least spacing between completed write bytes
`define MSP_GAP_NS 4000
`define MSP_CLK_MHZ 250

`endif

// ===== verilog/msp_sync.v
`default_nettype none

// Two-flop synchroniser for pin inputs
module msp_sync #(
    parameter WIDTH = 3
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= {WIDTH{1'b1}};
            syncOut <= {WIDTH{1'b1}};
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/msp_fifo.v
`default_nettype none

// Small flop FIFO with valid/ready on both sides
module msp_fifo #(
    parameter WIDTH = 17,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // Honest flags from the occupancy count
    assign inReady = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_q];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // Storage written only on push
    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap naturally since depth is a power of two
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== verilog/msp_serial_port.v
// What this block does
// - A transfer ends only after the addressed register's last bit moves.
// - Input data is sampled on each falling serial clock edge.
// - Output bits are launched on rising serial clock edges.
// - Chip select falling resets the port to wait for a command.
// - Chip select rising aborts the transfer and floats the output.
// - Command top bit one selects a write to the addressed register.
// - Command top bit zero selects a read of the addressed register.
// - Write data capture starts on the next falling edge after command.
// - A partly shifted write byte is dropped when select rises.
// - Up to five bytes; first byte lands in the top byte.
// - Data is right-justified; unused top bits of first byte ignored.
// - After a read command output drives from the next rising edge.
// - Output floats on the last falling edge of a read.
// - Select rising floats the output, even during a read.
// - Read copies the whole register into the shift path at once.
// - Checksum clears before the first read bit goes out.
// - Each launched read bit adds to the checksum.
// - Reading the checksum register also updates the checksum.
// - Five low bits of the command hold the register address.
// - After reset the port waits for a command byte.
// - Each completed transfer returns the port to command wait.
`include "msp_defines.vh"
`default_nettype none

module msp_serial_port (
    input wire clk,
    input wire rst,
    input wire sclk,
    input wire sdi,
    input wire csN,
    output reg sdo,
    output reg sdoEn,
    output reg regRdReq,
    output reg [`MSP_ADDR_W-1:0] regRdAddr,
    input wire [`MSP_SHIFT_W-1:0] regRdData,
    output wire wrValid,
    input wire wrReady,
    output wire [`MSP_ADDR_W-1:0] wrAddr,
    output wire [`MSP_SEL_W-1:0] wrByteSel,
    output wire wrLast,
    output wire [`MSP_BYTE_W-1:0] wrData,
    output reg wrOverrun,
    output reg gapError,
    output reg [`MSP_CHK_W-1:0] readChecksum
);

    // Port states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_CMD = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;
    localparam [1:0] ST_READ = 2'b11;

    // Byte spacing in clock cycles, rounded up
    localparam integer GAP_CYC_I = (`MSP_GAP_NS * `MSP_CLK_MHZ + 999) / 1000;
    localparam [10:0] GAP_CYC = GAP_CYC_I[10:0];

    // Width of each register in bits
    function [`MSP_CNT_W-1:0] regBits;
        input [`MSP_ADDR_W-1:0] a;
        begin
            case (a)
                `MSP_ADDR_WAVE: regBits = 6'h18;
                `MSP_ADDR_ENERGY: regBits = 6'h28;
                `MSP_ADDR_RENERGY: regBits = 6'h28;
                `MSP_ADDR_STAT: regBits = 6'h08;
                `MSP_ADDR_RSTAT: regBits = 6'h08;
                `MSP_ADDR_MODEREG: regBits = 6'h10;
                `MSP_ADDR_DIVDEN: regBits = 6'h0C;
                `MSP_ADDR_OFS1: regBits = 6'h08;
                `MSP_ADDR_OFS2: regBits = 6'h06;
                `MSP_ADDR_PGA: regBits = 6'h08;
                `MSP_ADDR_PWRGAIN: regBits = 6'h0C;
                `MSP_ADDR_PHASE: regBits = 6'h08;
                `MSP_ADDR_PWROFS: regBits = 6'h10;
                `MSP_ADDR_ZXTO: regBits = 6'h0C;
                `MSP_ADDR_SAGN: regBits = 6'h08;
                `MSP_ADDR_IRQMASK: regBits = 6'h08;
                `MSP_ADDR_CHECKSUM: regBits = 6'h06;
                default: regBits = `MSP_BITS_DEFAULT;
            endcase
        end
    endfunction

    // Bits on the wire: whole bytes covering the register
    function [`MSP_CNT_W-1:0] wireBits;
        input [`MSP_ADDR_W-1:0] a;
        reg [`MSP_CNT_W-1:0] b;
        begin
            b = regBits(a) + 6'h07;
            wireBits = {b[5:3], 3'b000};
        end
    endfunction

    // Synchronised pins
    wire sclkS;
    wire sdiS;
    wire csNS;
    reg sclkPrev_q;
    reg csPrev_q;
    wire sclkRise;
    wire sclkFall;
    wire csFall;

    // Shift and control state
    reg [1:0] state_q;
    reg [`MSP_BYTE_W-1:0] inSh_q;
    reg [`MSP_CNT_W-1:0] bitCnt_q;
    reg [`MSP_CNT_W-1:0] totalBits_q;
    reg [`MSP_CNT_W-1:0] regBits_q;
    reg [`MSP_ADDR_W-1:0] addr_q;
    reg [`MSP_SHIFT_W-1:0] outSh_q;
    reg loadPending_q;
    reg [10:0] gapCnt_q;

    // Combinational helpers
    wire [`MSP_BYTE_W-1:0] newByte;
    wire byteDone;
    reg [`MSP_BYTE_W-1:0] byteMask;
    reg [`MSP_SHIFT_W-1:0] snapData;
    reg [`MSP_SHIFT_W-1:0] snapMask;
    reg [`MSP_CNT_W-1:0] padShift;
    reg pushValid;
    wire pushReady;
    reg [`MSP_WQ_W-1:0] pushWord;
    wire [`MSP_WQ_W-1:0] popWord;
    wire [`MSP_SEL_W-1:0] byteNum;
    wire [`MSP_SEL_W-1:0] byteSel;
    wire [`MSP_SEL_W-1:0] lastNum;

    msp_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({sclk, sdi, csN}),
        .syncOut({sclkS, sdiS, csNS})
    );

    // Edge finders look only at the second sync stage
    always @(posedge clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b1;
            csPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclkS;
            csPrev_q <= csNS;
        end
    end

    assign sclkRise = sclkS & ~sclkPrev_q;
    assign sclkFall = ~sclkS & sclkPrev_q;
    assign csFall = ~csNS & csPrev_q;

    // Incoming byte with the fresh bit, MSB first
    assign newByte = {inSh_q[6:0], sdiS};
    assign byteDone = (bitCnt_q[2:0] == 3'b111);
    assign byteNum = bitCnt_q[5:3];
    assign lastNum = totalBits_q[5:3] - 3'b001;
    assign byteSel = lastNum - byteNum;

    // First byte keeps only the bits the register really has
    // right-justified first byte
    always @* begin
        byteMask = 8'hFF;
        if ((byteNum == 3'b000) && (regBits_q[2:0] != 3'b000)) begin
            byteMask = ~(8'hFF << regBits_q[2:0]);
        end
    end

    // Write byte word toward the FIFO
    always @* begin
        pushValid = 1'b0;
        pushWord = {addr_q, byteSel, (byteNum == lastNum), newByte & byteMask};
        if ((state_q == ST_WRITE) && sclkFall && csFall == 1'b0 && byteDone && ~csNS) begin
            pushValid = 1'b1;
        end
    end

    // Read snapshot source, zero padded above the register width
    always @* begin
        snapMask = ~({`MSP_SHIFT_W{1'b1}} << regBits_q);
        snapData = regRdData & snapMask;
        if (addr_q == `MSP_ADDR_CHECKSUM) begin
            snapData = {{(`MSP_SHIFT_W-`MSP_CHK_W){1'b0}}, readChecksum};
        end
        padShift = 6'h28 - totalBits_q;
    end

    // Main sequencer
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_CMD;
            inSh_q <= 8'h00;
            bitCnt_q <= 6'h00;
            totalBits_q <= `MSP_CMD_BITS;
            regBits_q <= `MSP_BITS_DEFAULT;
            addr_q <= 5'h00;
            outSh_q <= 40'h00_0000_0000;
            sdo <= 1'b0;
            sdoEn <= 1'b0;
            regRdReq <= 1'b0;
            regRdAddr <= 5'h00;
            loadPending_q <= 1'b0;
            readChecksum <= 6'h00;
        end else begin
            regRdReq <= 1'b0;
            if (csNS) begin
                // a half byte is simply never pushed
                // output floats while select is high
                state_q <= ST_IDLE;
                sdoEn <= 1'b0;
                loadPending_q <= 1'b0;
                bitCnt_q <= 6'h00;
            end else if (csFall) begin
                state_q <= ST_CMD;
                bitCnt_q <= 6'h00;
                sdoEn <= 1'b0;
                loadPending_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_CMD: begin
                        if (sclkFall) begin
                            inSh_q <= newByte;
                            bitCnt_q <= bitCnt_q + 6'h01;
                            if (byteDone) begin
                                addr_q <= newByte[`MSP_ADDR_W-1:0];
                                regBits_q <= regBits(newByte[`MSP_ADDR_W-1:0]);
                                totalBits_q <= wireBits(newByte[`MSP_ADDR_W-1:0]);
                                bitCnt_q <= 6'h00;
                                if (newByte[`MSP_CMD_WRITE_BIT]) begin
                                    // data capture from next falling edge
                                    state_q <= ST_WRITE;
                                end else begin
                                    // read command asks for a snapshot
                                    state_q <= ST_READ;
                                    regRdReq <= 1'b1;
                                    regRdAddr <= newByte[`MSP_ADDR_W-1:0];
                                    loadPending_q <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (sclkFall) begin
                            inSh_q <= newByte;
                            bitCnt_q <= bitCnt_q + 6'h01;
                            // done only after the register LSB arrives
                            if (bitCnt_q == totalBits_q - 6'h01) begin
                                state_q <= ST_CMD;
                                bitCnt_q <= 6'h00;
                            end
                        end
                    end
                    ST_READ: begin
                        if (loadPending_q) begin
                            // whole register captured in one cycle
                            // unused top bits leave as zeros, MSB first
                            outSh_q <= snapData << padShift;
                            readChecksum <= 6'h00;
                            loadPending_q <= 1'b0;
                        end else if (sclkRise && bitCnt_q != totalBits_q) begin
                            sdo <= outSh_q[`MSP_SHIFT_W-1];
                            sdoEn <= 1'b1;
                            outSh_q <= {outSh_q[`MSP_SHIFT_W-2:0], 1'b0};
                            bitCnt_q <= bitCnt_q + 6'h01;
                            // count ones as they go out
                            // same path when checksum itself is read
                            readChecksum <= readChecksum + {5'b00000, outSh_q[`MSP_SHIFT_W-1]};
                        end else if (sclkFall && bitCnt_q == totalBits_q) begin
                            sdoEn <= 1'b0;
                            state_q <= ST_CMD;
                            bitCnt_q <= 6'h00;
                        end
                    end
                    ST_IDLE: begin
                        // Tied-low select never returns here
                        state_q <= ST_IDLE;
                    end
                    default: begin
                        state_q <= ST_CMD;
                    end
                endcase
            end
        end
    end

    // Write byte buffer; a full buffer drops the byte and flags it
    msp_fifo #(
        .WIDTH(`MSP_WQ_W),
        .DEPTH(`MSP_WQ_DEPTH),
        .AW(3)
    ) u_wq (
        .clk(clk),
        .rst(rst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData(popWord)
    );

    // byte select counts down from the top byte
    assign wrAddr = popWord[16:12];
    assign wrByteSel = popWord[11:9];
    assign wrLast = popWord[8];
    assign wrData = popWord[7:0];

    // Overrun is sticky until reset; set is the only event
    always @(posedge clk) begin
        if (rst) begin
            wrOverrun <= 1'b0;
        end else if (pushValid & ~pushReady) begin
            wrOverrun <= 1'b1;
        end
    end

    // Spacing watch: host must leave the register side time to absorb bytes
    always @(posedge clk) begin
        if (rst) begin
            gapCnt_q <= GAP_CYC;
            gapError <= 1'b0;
        end else begin
            gapError <= 1'b0;
            if (pushValid) begin
                // byte completed too soon after the last one
                if (gapCnt_q != GAP_CYC) begin
                    gapError <= 1'b1;
                end
                gapCnt_q <= 11'h000;
            end else if (regRdReq && gapCnt_q != GAP_CYC) begin
                // read command too soon after a write byte
                gapError <= 1'b1;
            end else if (gapCnt_q != GAP_CYC) begin
                gapCnt_q <= gapCnt_q + 11'h001;
            end
        end
    end

endmodule

`default_nettype wire

// ===== sim/msp_serial_port_asserts.sv
`include "msp_defines.vh"
`default_nettype none
module msp_serial_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic csN,
    input wire logic sdo,
    input wire logic sdoEn,
    input wire logic regRdReq,
    input wire logic [`MSP_ADDR_W-1:0] regRdAddr,
    input wire logic [`MSP_SHIFT_W-1:0] regRdData,
    input wire logic wrValid,
    input wire logic wrReady,
    input wire logic [`MSP_ADDR_W-1:0] wrAddr,
    input wire logic [`MSP_SEL_W-1:0] wrByteSel,
    input wire logic wrLast,
    input wire logic [`MSP_BYTE_W-1:0] wrData,
    input wire logic wrOverrun,
    input wire logic gapError,
    input wire logic [`MSP_CHK_W-1:0] readChecksum
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Pins pass two sync flops, so causes are looked up two clocks back
    AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> !sdoEn && !wrValid && !regRdReq
        && !wrOverrun && !gapError && readChecksum == 0) else $error("outputs not idle after reset");
    AST_CS_HIGH_FLOAT: assert property (csN [*6] |-> !sdoEn) else $error("sdo driven while deselected");
    AST_LAUNCH_ON_RISE: assert property (sdoEn && $past(sdoEn) && sdo != $past(sdo) |-> $past(sclk, 2))
        else $error("sdo changed away from a rising sclk");
    AST_DRIVE_START: assert property ($rose(sdoEn) |-> $past(sclk, 2) && !$past(csN, 2))
        else $error("sdo drive began off a rising sclk");
    AST_FLOAT_END: assert property ($fell(sdoEn) |-> !$past(sclk, 2) || $past(csN, 2))
        else $error("sdo released at a wrong moment");
    AST_REQ_CAUSE: assert property (regRdReq |-> !$past(csN, 2) && !$past(sclk, 2))
        else $error("read request without a falling sclk");
    AST_CHK_CLEAR: assert property (regRdReq |-> ##3 readChecksum == 0) else $error("checksum not cleared");
    AST_WR_HOLD: assert property (wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrByteSel, wrLast, wrData}))
        else $error("write word changed while stalled");
    AST_WR_LAST_SEL: assert property (wrValid && wrLast |-> wrByteSel == 0) else $error("last byte not lowest");
    AST_WR_MASK: assert property (wrValid && wrAddr == `MSP_ADDR_DIVDEN && wrByteSel == 1 |-> wrData[7:4] == 0)
        else $error("unused top bits not masked");
    AST_GAP_CAUSE: assert property (gapError |-> !$past(sclk, 2) && !$past(csN, 2))
        else $error("gap flag without a byte end");
    // Main scenarios reached
    COV_READ: cover property (regRdReq);
    COV_WRITE: cover property (wrValid && wrReady && wrLast);
    COV_FULL: cover property ($rose(wrOverrun));
    COV_GAP: cover property (gapError);
endmodule
bind msp_serial_port msp_serial_port_chk chk (.clk(clk), .rst(rst), .sclk(sclk), .sdi(sdi), .csN(csN),
    .sdo(sdo), .sdoEn(sdoEn), .regRdReq(regRdReq), .regRdAddr(regRdAddr), .regRdData(regRdData),
    .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrByteSel(wrByteSel), .wrLast(wrLast),
    .wrData(wrData), .wrOverrun(wrOverrun), .gapError(gapError), .readChecksum(readChecksum));
`default_nettype wire

// ===== sim/msp_host.sv
`include "msp_defines.vh"
`default_nettype none
module msp_host (
    input wire logic clk,
    output logic sclk,
    output logic sdi,
    output logic csN,
    input wire logic sdo,
    input wire logic sdoEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hurry = 1'b0;
    logic lastOut = 1'b0;
    logic endEn = 1'b0;
    realtime lastWr = -1.0e6;
    // Floating line shows the inverse, so a stale bit never passes
    wire line = sdoEn ? sdo : ~lastOut;
    initial begin
        sclk = 1'b1;
        sdi = 1'b0;
        csN = 1'b1;
    end
    always @(posedge clk) if (sdoEn) lastOut <= sdo;
    task automatic half();
        repeat (10) @(negedge clk);
    endtask
    // frames run to the last bit unless cut on purpose
    task automatic xfer(input logic [7:0] cmd, input logic [39:0] wd, input int n, input int cut,
        output logic [39:0] rd);
        rd = '0;
        csN = 1'b0;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 8 + 8 * n; k++) begin
            if (cut > 0 && k == 8 + cut) break;
            while (!hurry && k % 8 == 0 && $realtime - lastWr < `MSP_GAP_NS + 200) @(negedge clk);
            // bit valid before the falling edge, MSB first
            sdi = k < 8 ? cmd[7 - k] : wd[8 * n - 1 - (k - 8)];
            half();
            if (k >= 8) rd = {rd[38:0], line};
            sclk = 1'b0;
            half();
            sclk = 1'b1;
            if (cmd[7] && k >= 8 && k % 8 == 7) lastWr = $realtime;
        end
        half();
        endEn = sdoEn;
        sdi = ~sdi;
        csN = 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ===== sim/msp_serial_port_test.sv
`include "msp_defines.vh"
`default_nettype none
module msp_serial_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wrReady = 1'b0, sawGap = 1'b0, chkOn = 1'b1;
    logic [1:0] rdyMode = 2'h0;
    logic [5:0] lastChk = 6'h00;
    logic [`MSP_SHIFT_W-1:0] regRdData = '0, rdVal = '0, dmy;
    logic [31:0] seed = 32'hACF6335C;
    wire sclk, sdi, csN, sdo, sdoEn, regRdReq, wrValid, wrLast, wrOverrun, gapError;
    wire [`MSP_ADDR_W-1:0] regRdAddr, wrAddr;
    wire [`MSP_SEL_W-1:0] wrByteSel;
    wire [`MSP_BYTE_W-1:0] wrData;
    wire [`MSP_CHK_W-1:0] readChecksum;
    int fails = 0, samples_checked = 0;
    logic [`MSP_WQ_W-1:0] expQ[$];
    msp_serial_port dut (.clk(clk), .rst(rst), .sclk(sclk), .sdi(sdi), .csN(csN), .sdo(sdo), .sdoEn(sdoEn),
        .regRdReq(regRdReq), .regRdAddr(regRdAddr), .regRdData(regRdData), .wrValid(wrValid),
        .wrReady(wrReady), .wrAddr(wrAddr), .wrByteSel(wrByteSel), .wrLast(wrLast), .wrData(wrData),
        .wrOverrun(wrOverrun), .gapError(gapError), .readChecksum(readChecksum));
    msp_host host (.clk(clk), .sclk(sclk), .sdi(sdi), .csN(csN), .sdo(sdo), .sdoEn(sdoEn));
    initial forever #2 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [39:0] rnd40();
        return {lfsr(seed), seed[7:0]};
    endfunction
    function automatic int wbits(input logic [4:0] a);
        case (a)
            `MSP_ADDR_WAVE: return 24;
            `MSP_ADDR_ENERGY, `MSP_ADDR_RENERGY: return 40;
            `MSP_ADDR_MODEREG, `MSP_ADDR_PWROFS: return 16;
            `MSP_ADDR_DIVDEN, `MSP_ADDR_PWRGAIN, `MSP_ADDR_ZXTO: return 12;
            `MSP_ADDR_OFS2: return 6;
            default: return 8;
        endcase
    endfunction
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Register side noise; snapshot value only in the load cycle
    always @(negedge clk) begin
        seed <= lfsr(seed);
        regRdData <= regRdReq ? rdVal : rnd40();
        wrReady <= rdyMode[1] ? seed[3] : rdyMode[0];
    end
    // Popped write words against the expected queue
    always @(posedge clk) begin
        if (chkOn && wrValid === 1'b1 && wrReady) check(wrAddr_word(), expQ.pop_front());
        if (gapError === 1'b1) sawGap <= 1'b1;
    end
    function automatic logic [39:0] wrAddr_word();
        return {wrAddr, wrByteSel, wrLast, wrData};
    endfunction
    task automatic wr(input logic [4:0] a, input logic [39:0] d);
        int n;
        logic [39:0] m;
        n = (wbits(a) + 7) / 8;
        m = (40'h1 << wbits(a)) - 40'h1;
        for (int i = n - 1; i >= 0; i--) expQ.push_back({a, 3'(i), 1'(i == 0), 8'((d & m) >> (8 * i))});
        host.xfer({3'h4, a}, d, n, 0, dmy);
    endtask
    task automatic rd(input logic [4:0] a);
        logic [39:0] got, e;
        rdVal = rnd40();
        e = a == `MSP_ADDR_CHECKSUM ? 40'(lastChk) : rdVal & ((40'h1 << wbits(a)) - 40'h1);
        host.xfer({3'h0, a}, rnd40(), (wbits(a) + 7) / 8, 0, got);
        lastChk = 6'($countones(e));
        check(got, e);
        check(regRdAddr, a);
        check(readChecksum, lastChk);
        check(host.endEn, 0);
    endtask
    task automatic drain();
        for (int i = 0; i < 4000 && expQ.size() > 0; i++) @(negedge clk);
        check(expQ.size(), 0);
    endtask
    initial begin
        #320us;
        fails++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check({sdoEn, wrValid, wrOverrun, readChecksum}, 0);
        rdyMode = 2'h2;
        for (int a = 6; a <= 16; a++) wr(5'(a), rnd40());
        drain();
        for (int a = 1; a <= 17; a++) begin
            rd(5'(a));
            if (a[0]) rd(`MSP_ADDR_CHECKSUM);
        end
        // Cut write: only the completed first byte survives
        dmy = rnd40();
        expQ.push_back({`MSP_ADDR_MODEREG, 3'h1, 1'b0, dmy[15:8]});
        host.xfer({3'h4, `MSP_ADDR_MODEREG}, dmy, 2, 12, dmy);
        wr(`MSP_ADDR_PWRGAIN, rnd40());
        drain();
        // Cut read floats the line, next frame starts clean
        host.xfer({3'h0, `MSP_ADDR_ENERGY}, 40'h0, 5, 5, dmy);
        check(sdoEn, 0);
        rd(`MSP_ADDR_ENERGY);
        // Full FIFO drops the ninth and tenth bytes and flags it
        rdyMode = 2'h0;
        repeat (5) wr(`MSP_ADDR_MODEREG, rnd40());
        while (expQ.size() > 8) void'(expQ.pop_back());
        check(wrOverrun, 1);
        rdyMode = 2'h2;
        drain();
        check(sawGap, 0);
        chkOn = 1'b0;
        host.hurry = 1'b1;
        wr(`MSP_ADDR_MODEREG, rnd40());
        check(sawGap, 1);
        final_report();
    end
endmodule
`default_nettype wire
